// *** adc_feed.sv ***
// ADC sample source for the accumulator.
`timescale 1ns/1ps
`default_nettype none
module adc_feed (
    input  wire logic       clk,
    input  wire logic       go,
    output logic            adc_valid,
    output logic [9:0]      adc_data,
    output logic            feed_busy
);
    initial {adc_valid, adc_data, feed_busy} = '0;
    always @(posedge go) begin
        feed_busy = 1;
        repeat (16) begin
            @(posedge clk);
            #1 adc_valid = 1;
            adc_data = 10'h3FF;
            @(posedge clk);
            #1 adc_valid = 0;
            adc_data = ~adc_data;
        end
        feed_busy = 0;
    end
endmodule
`default_nettype wire

// *** rail2_regs_defines.vh ***
// Offsets, fields, reset values and timing of the rail-2 status bank.
`ifndef RAIL2_REGS_DEFINES_VH
`define RAIL2_REGS_DEFINES_VH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define REG_TRIM_C          8'h9B
`define REG_TRIM_D          8'h9D
`define REG_BUS_OPTIONS     8'h9E
`define REG_ADC_ACCUM       8'hA0
`define REG_STORE_STATUS    8'hA1
`define REG_CODE_LOW        8'hA4
`define REG_CODE_HIGH       8'hA5
`define REG_FAULT_FIRST     8'hA6

// ----------------------------------------
// Trim fields
// ----------------------------------------
`define TRIM_W              5
`define TRIM_HI_LSB         10
`define TRIM_MID_LSB        5
`define TRIM_LO_LSB         0
`define TRIM_C_MASK         16'h7FFF
`define TRIM_D_MASK         16'h03FF
`define TRIM_RST            16'h0000

// ----------------------------------------
// Bus options fields
// ----------------------------------------
`define OPT_BLANK_LSB       10
`define OPT_BLANK_W         6
`define OPT_TRANS_SEL       9
`define OPT_WARN_DIS        8
`define OPT_BOTH_SEL        7
`define OPT_EN_DONE         6
`define OPT_EN_OC           5
`define OPT_EN_UV           4
`define OPT_EN_OP           3
`define OPT_EN_OT           2
`define OPT_ROUTE_LSB       0
`define ROUTE_NONE          2'h0
`define ROUTE_ALERT         2'h1
`define ROUTE_HOT           2'h2
`define OPT_RST             16'h0000

// ----------------------------------------
// Accumulator, store status, trackers and faults
// ----------------------------------------
`define ADC_SUM_W           14
`define ADC_SUM_N           5'h10
`define ADC_RDY_BIT         14
`define ST_VERIFY_ERR       6
`define ST_RESTORE_ACT      5
`define ST_WR_FAIL          4
`define ST_STROBE_ACT       3
`define ST_LIVE_BUSY        2
`define ST_BUSY_OUT         1
`define ST_SELECT_IN        0
`define CODE_W              12
`define CODE_LOW_RELOAD     12'h1FF
`define CODE_HIGH_RELOAD    12'h000
`define FLT_SELF_R2         15
`define FLT_SELF_R1         14
`define FLT_INPUT           13
`define FLT_STAGE_R2        11
`define FLT_STAGE_R1        10
`define FLT_TEMP_R2         9
`define FLT_TEMP_R1         8
`define FLT_PH_R2_LSB       4
`define FLT_PH_R1_LSB       0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS       20
`define BLANK_LSB_NS        3375000
`define BLANK_LSB_CYCLES    ((`BLANK_LSB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rail2_regs_props.sv ***
// Assertions on the ports of the rail-2 status and options bank.
`timescale 1ns/1ps
`default_nettype none
module rail2_regs_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] rd_data_q,
    input wire logic        rd_valid_q,
    input wire logic        power_alert_req,
    input wire logic        input_power_alert_out_n,
    input wire logic        get_status,
    input wire logic        status_frame_req_q,
    input wire logic        store_restore_active,
    input wire logic        store_busy_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    trim_c_sign_a: assert property (rd_valid_q && $past(cmd_code) == 8'h9B |-> !rd_data_q[15])
        else $error("trim c bit 15");
    trim_d_top_a: assert property (rd_valid_q && $past(cmd_code) == 8'h9D |-> rd_data_q[15:10] == 6'h00)
        else $error("trim d top");
    store_live_a: assert property (rd_valid_q && $past(cmd_code) == 8'hA1 |-> rd_data_q[15:7] == 9'h000
        && rd_data_q[5] == $past(store_restore_active) && rd_data_q[1] == $past(store_busy_out))
        else $error("store word");
    code_top_a: assert property (rd_valid_q && $past(cmd_code) inside {8'hA4, 8'hA5} |-> rd_data_q[15:12] == 4'h0)
        else $error("tracker top");
    fault_gaps_a: assert property (rd_valid_q && $past(cmd_code) == 8'hA6 |-> !rd_data_q[12] && !rd_data_q[7])
        else $error("fault gaps");
    accum_top_a: assert property (rd_valid_q && $past(cmd_code) == 8'hA0 |-> !rd_data_q[15])
        else $error("accum bit 15");
    alert_low_a: assert property (power_alert_req |=> !input_power_alert_out_n)
        else $error("no alert");
    frame_req_a: assert property (get_status |=> status_frame_req_q)
        else $error("no frame request");
endmodule
bind rail2_status_avs_config_regs rail2_regs_props rail2_regs_props_i (.*);
`default_nettype wire

// *** rail2_status_avs_config_regs.v ***
// Rail-1 and rail-2 phase offset trims, adaptive bus options, ADC accumulator, store status, code trackers and first fault word.
`timescale 1ns/1ps
`default_nettype none
`include "rail2_regs_defines.vh"

// What this block does
// R1 - Reserved bits read zero; writes to them are dropped.
// R2 - Trims are five-bit signed fields at 14:10, 9:5, 4:0.
// R3 - Shared trim applies to rail-1 phase or rail-2 phase by assignment.
// R4 - Fourth trim word: 15:10 reserved, 9:5 trims phase twelve only.
// R5 - Options 15:10 set power alert release blanking, 3.375 ms per step.
// R6 - Bit 9 adds response frames when transition done is set.
// R7 - Bit 8 clear sends frames on warning changes under host code control.
// R8 - Bit 7 chooses either-rail or both-rail settling for the frame.
// R9 - Bits 6..2 unmask done, current, voltage, power, temperature triggers.
// R10 - Bits 1:0 choose which pins carry the adaptive bus lines.
// R11 - Accumulate command sums sixteen ADC results, then sets ready bit 14.
// R12 - Verify error set on mismatch, cleared by a new verify command.
// R13 - Bit 5 high while a store or restore runs.
// R14 - Write failure set on failed store, cleared by next store command.
// R15 - Bits 3, 1, 0 show strobe active, store busy, store select.
// R16 - Bit 2 shows the store live busy state to the host.
// R17 - Low tracker keeps lowest code, reloads 0x01FF on set-code command.
// R18 - High tracker keeps highest code, reloads zero on set-code command.
// R19 - Input fault: live current warning or latched power fault by source.
// R20 - Bits 11,10 power-stage faults; bits 9,8 temperature alone.
// R21 - Bits 15,14 show modulator self faults on rail 2 and rail 1.
// R22 - Fault phase codes: rail 2 at 6:4, rail 1 at 3:0.
// R23 - Trim code scales to current by 12.8/1023 over gain and resistor.
// R24 - Writes to read-only words change nothing, except a write to 0xA0, which restarts the accumulator.
// R25 - Trims are added to the sense values before later use.

module rail2_status_avs_config_regs #(
    parameter SENSE_W          = 10,
    parameter ADC_W            = 10,
    parameter BLANK_LSB_CYCLES = `BLANK_LSB_CYCLES
) (
    input  wire                 clk,
    input  wire                 rst,
    input  wire [7:0]           cmd_code,
    input  wire                 cmd_wr,
    input  wire [15:0]          cmd_wdata,
    input  wire                 cmd_rd,
    output reg  [15:0]          rd_data_q,
    output reg                  rd_valid_q,
    input  wire [5*SENSE_W-1:0] rail1_sense_raw,
    input  wire [4*SENSE_W-1:0] rail2_sense_raw,
    input  wire [3:0]           phase_on_rail2,
    output wire [5*SENSE_W-1:0] rail1_sense_trimmed,
    output wire [4*SENSE_W-1:0] rail2_sense_trimmed,
    input  wire                 power_alert_req,
    output reg                  input_power_alert_out_n,
    input  wire                 avs_mode,
    input  wire                 override_mode,
    input  wire                 code_from_host,
    input  wire                 dvid_active,
    input  wire                 get_status,
    input  wire                 transition_done_flag,
    input  wire                 rail1_settled,
    input  wire                 rail2_settled,
    input  wire                 overcurrent_warning,
    input  wire                 undervoltage_warning,
    input  wire                 overpower_warning,
    input  wire                 overtemp_warning,
    output reg                  status_frame_req_q,
    input  wire                 sclk_pin,
    input  wire                 sdio_pin,
    input  wire                 avs_clk_pin,
    input  wire                 avs_mosi_pin,
    input  wire                 avs_miso_data,
    input  wire                 hot_alert_req,
    input  wire                 alert_req,
    output wire                 hot_alert_pin_o,
    output reg                  hot_alert_pin_oe_n,
    output wire                 alert_pin_o,
    output reg                  alert_pin_oe_n,
    output reg                  avs_miso_pin_q,
    output reg                  avs_clk_q,
    output reg                  avs_mosi_q,
    input  wire [ADC_W-1:0]     adc_data,
    input  wire                 adc_valid,
    input  wire                 verify_begin_command,
    input  wire                 verify_mismatch,
    input  wire                 store_command,
    input  wire                 store_write_fail,
    input  wire                 store_restore_active,
    input  wire                 store_strobe_active,
    input  wire                 store_live_busy,
    input  wire                 store_busy_out,
    input  wire                 store_select_in,
    input  wire                 set_code_cmd,
    input  wire [11:0]          voltage_code,
    input  wire                 voltage_code_valid,
    input  wire                 input_protection_source,
    input  wire                 clear_faults,
    input  wire                 iin_above_warn_pin,
    input  wire                 pin_above_fault_pin,
    input  wire                 rail2_temp_sense_pin,
    input  wire                 rail1_temp_sense_pin,
    input  wire                 rail2_cs_low_pin,
    input  wire                 rail1_cs_low_pin,
    input  wire                 rail2_modulator_self_fault,
    input  wire                 rail1_modulator_self_fault,
    input  wire [2:0]           rail2_sense_fault_phase,
    input  wire [3:0]           rail1_sense_fault_phase
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg  [9:0] pin_meta_q;
    reg  [9:0] pin_sync_q;

    always @(posedge clk) begin
        if (rst) begin
            pin_meta_q <= 10'h000;
            pin_sync_q <= 10'h000;
        end else begin
            pin_meta_q <= {avs_mosi_pin, avs_clk_pin, sdio_pin, sclk_pin, rail1_cs_low_pin, rail2_cs_low_pin,
                           rail1_temp_sense_pin, rail2_temp_sense_pin, pin_above_fault_pin, iin_above_warn_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    wire iin_warn_s  = pin_sync_q[0];
    wire pin_fault_s = pin_sync_q[1];
    wire temp2_s     = pin_sync_q[2];
    wire temp1_s     = pin_sync_q[3];
    wire cs2_low_s   = pin_sync_q[4];
    wire cs1_low_s   = pin_sync_q[5];
    wire sclk_s      = pin_sync_q[6];
    wire sdio_s      = pin_sync_q[7];
    wire avs_clk_s   = pin_sync_q[8];
    wire avs_mosi_s  = pin_sync_q[9];

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    reg  [15:0] trim_c_q;
    reg  [15:0] trim_d_q;
    reg  [15:0] options_q;

    always @(posedge clk) begin
        if (rst) begin
            trim_c_q  <= `TRIM_RST;
            trim_d_q  <= `TRIM_RST;
            options_q <= `OPT_RST;
        end else if (cmd_wr) begin
            case (cmd_code)
                `REG_TRIM_C:      trim_c_q  <= cmd_wdata & `TRIM_C_MASK; // [R1] [R2]
                `REG_TRIM_D:      trim_d_q  <= cmd_wdata & `TRIM_D_MASK; // [R1] [R4]
                `REG_BUS_OPTIONS: options_q <= cmd_wdata;
                default:          trim_c_q  <= trim_c_q; // [R24]
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Trim application
    // ------------------------------------------------------------------------
    // Field k: 0..2 from the third word, 3..4 from the fourth word.
    wire [24:0] trim_fields = {trim_d_q[`TRIM_MID_LSB +: `TRIM_W], trim_d_q[`TRIM_LO_LSB +: `TRIM_W],
                               trim_c_q[`TRIM_HI_LSB +: `TRIM_W], trim_c_q[`TRIM_MID_LSB +: `TRIM_W],
                               trim_c_q[`TRIM_LO_LSB +: `TRIM_W]};
    wire [4:0]  on_rail2 = {1'b0, phase_on_rail2};

    genvar k;
    generate
        for (k = 0; k < 5; k = k + 1) begin : g_rail1
            trim_apply #(.SENSE_W(SENSE_W)) u_trim (
                .clk         (clk),
                .rst         (rst),
                .sense       (rail1_sense_raw[k*SENSE_W +: SENSE_W]),
                .trim        (on_rail2[k] ? 5'h00 : trim_fields[k*5 +: 5]), // [R3] [R23]
                .corrected_q (rail1_sense_trimmed[k*SENSE_W +: SENSE_W])   // [R25]
            );
        end
        for (k = 0; k < 4; k = k + 1) begin : g_rail2
            trim_apply #(.SENSE_W(SENSE_W)) u_trim (
                .clk         (clk),
                .rst         (rst),
                .sense       (rail2_sense_raw[k*SENSE_W +: SENSE_W]),
                .trim        (on_rail2[k] ? trim_fields[k*5 +: 5] : 5'h00), // [R3] [R4]
                .corrected_q (rail2_sense_trimmed[k*SENSE_W +: SENSE_W])   // [R25]
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Power alert release blanking
    // ------------------------------------------------------------------------
    reg  [17:0] blank_pre_q;
    reg  [5:0]  blank_cnt_q;
    wire [5:0]  blank_len = options_q[`OPT_BLANK_LSB +: `OPT_BLANK_W];

    always @(posedge clk) begin
        if (rst) begin
            input_power_alert_out_n <= 1'b1;
            blank_pre_q             <= 18'h00000;
            blank_cnt_q             <= 6'h00;
        end else if (power_alert_req) begin
            input_power_alert_out_n <= 1'b0;
            blank_pre_q             <= 18'h00000;
            blank_cnt_q             <= 6'h00;
        end else if (!input_power_alert_out_n) begin
            if (blank_cnt_q >= blank_len) begin
                input_power_alert_out_n <= 1'b1; // [R5]
            end else if (blank_pre_q == BLANK_LSB_CYCLES[17:0] - 18'h00001) begin
                blank_pre_q <= 18'h00000;
                blank_cnt_q <= blank_cnt_q + 6'h01; // [R5]
            end else begin
                blank_pre_q <= blank_pre_q + 18'h00001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Status response frame triggers
    // ------------------------------------------------------------------------
    reg  [3:0] warn_prev_q;
    reg        done_prev_q;
    reg        settle_prev_q;
    wire [3:0] warn_now = {overcurrent_warning, undervoltage_warning, overpower_warning, overtemp_warning};
    wire [3:0] warn_en  = options_q[`OPT_EN_OT +: 4]; // [R9]
    wire       settle_now = options_q[`OPT_BOTH_SEL] ? (rail1_settled & rail2_settled)
                                                     : (rail1_settled | rail2_settled); // [R8]
    wire       settle_evt = override_mode & settle_now & ~settle_prev_q & options_q[`OPT_EN_DONE]; // [R8] [R9]
    wire       done_evt   = dvid_active & options_q[`OPT_TRANS_SEL] & options_q[`OPT_EN_DONE]
                            & transition_done_flag & ~done_prev_q; // [R6]
    wire       warn_evt   = avs_mode & code_from_host & ~options_q[`OPT_WARN_DIS]
                            & (|((warn_now ^ warn_prev_q) & warn_en)); // [R7] [R9]

    always @(posedge clk) begin
        if (rst) begin
            warn_prev_q        <= 4'h0;
            done_prev_q        <= 1'b0;
            settle_prev_q      <= 1'b0;
            status_frame_req_q <= 1'b0;
        end else begin
            warn_prev_q        <= warn_now;
            done_prev_q        <= transition_done_flag;
            settle_prev_q      <= settle_now;
            status_frame_req_q <= get_status | done_evt | settle_evt | warn_evt; // [R6]
        end
    end

    // ------------------------------------------------------------------------
    // Adaptive bus pin routing
    // ------------------------------------------------------------------------
    wire [1:0] route = options_q[`OPT_ROUTE_LSB +: 2];
    wire       routed = override_mode & ((route == `ROUTE_HOT) | (route == `ROUTE_ALERT));

    assign hot_alert_pin_o = 1'b0;
    assign alert_pin_o     = 1'b0;

    always @(posedge clk) begin
        if (rst) begin
            hot_alert_pin_oe_n <= 1'b1;
            alert_pin_oe_n     <= 1'b1;
            avs_miso_pin_q     <= 1'b1;
            avs_clk_q          <= 1'b0;
            avs_mosi_q         <= 1'b0;
        end else begin
            hot_alert_pin_oe_n <= (override_mode && route == `ROUTE_HOT) ? avs_miso_data : ~hot_alert_req; // [R10]
            alert_pin_oe_n     <= (override_mode && route == `ROUTE_ALERT) ? avs_miso_data : ~alert_req;   // [R10]
            avs_miso_pin_q     <= routed ? 1'b1 : avs_miso_data;
            avs_clk_q          <= routed ? sclk_s : avs_clk_s;  // [R10]
            avs_mosi_q         <= routed ? sdio_s : avs_mosi_s; // [R10]
        end
    end

    // ------------------------------------------------------------------------
    // ADC accumulator
    // ------------------------------------------------------------------------
    reg  [`ADC_SUM_W-1:0] acc_q;
    reg  [4:0]            acc_cnt_q;
    reg                   acc_run_q;
    reg                   acc_rdy_q;
    wire                  acc_start = (cmd_wr | cmd_rd) & (cmd_code == `REG_ADC_ACCUM);
    wire [`ADC_SUM_W-1:0] acc_sum = acc_q + {{(`ADC_SUM_W-ADC_W){1'b0}}, adc_data};

    always @(posedge clk) begin
        if (rst) begin
            acc_q     <= {`ADC_SUM_W{1'b0}};
            acc_cnt_q <= 5'h00;
            acc_run_q <= 1'b0;
            acc_rdy_q <= 1'b0;
        end else if (acc_start) begin
            acc_q     <= {`ADC_SUM_W{1'b0}}; // [R11]
            acc_cnt_q <= 5'h00;
            acc_run_q <= 1'b1;
            acc_rdy_q <= 1'b0;
        end else if (acc_run_q && adc_valid) begin
            acc_q     <= acc_sum;
            acc_cnt_q <= acc_cnt_q + 5'h01;
            if (acc_cnt_q == `ADC_SUM_N - 5'h01) begin
                acc_run_q <= 1'b0;
                acc_rdy_q <= 1'b1; // [R11]
            end
        end
    end

    // ------------------------------------------------------------------------
    // Store status flags
    // ------------------------------------------------------------------------
    reg verify_err_q;
    reg wr_fail_q;

    always @(posedge clk) begin
        if (rst) begin
            verify_err_q <= 1'b0;
            wr_fail_q    <= 1'b0;
        end else begin
            verify_err_q <= verify_mismatch | (verify_err_q & ~verify_begin_command); // [R12]
            wr_fail_q    <= store_write_fail | (wr_fail_q & ~store_command);         // [R14]
        end
    end

    wire [15:0] store_word = {9'h000, verify_err_q, store_restore_active, wr_fail_q, store_strobe_active,
                              store_live_busy, store_busy_out, store_select_in}; // [R13] [R15] [R16]

    // ------------------------------------------------------------------------
    // Output code trackers
    // ------------------------------------------------------------------------
    reg  [`CODE_W-1:0] code_low_q;
    reg  [`CODE_W-1:0] code_high_q;

    always @(posedge clk) begin
        if (rst) begin
            code_low_q  <= `CODE_LOW_RELOAD;
            code_high_q <= `CODE_HIGH_RELOAD;
        end else if (set_code_cmd) begin
            code_low_q  <= `CODE_LOW_RELOAD;  // [R17]
            code_high_q <= `CODE_HIGH_RELOAD; // [R18]
        end else if (voltage_code_valid) begin
            if (voltage_code < code_low_q) begin
                code_low_q <= voltage_code; // [R17]
            end
            if (voltage_code > code_high_q) begin
                code_high_q <= voltage_code; // [R18]
            end
        end
    end

    // ------------------------------------------------------------------------
    // First fault word
    // ------------------------------------------------------------------------
    reg input_latch_q;

    always @(posedge clk) begin
        if (rst) begin
            input_latch_q <= 1'b0;
        end else begin
            input_latch_q <= (~input_protection_source & pin_fault_s) | (input_latch_q & ~clear_faults); // [R19]
        end
    end

    wire input_fault_flag = input_protection_source ? iin_warn_s : input_latch_q; // [R19]
    wire [2:0] ph2_code = (rail2_sense_fault_phase == 3'h7) ? 3'h0 : rail2_sense_fault_phase;  // [R22]
    wire [3:0] ph1_code = (rail1_sense_fault_phase > 4'hC) ? 4'h0 : rail1_sense_fault_phase;   // [R22]
    wire [15:0] fault_word = {rail2_modulator_self_fault, rail1_modulator_self_fault, input_fault_flag, 1'b0,
                              temp2_s | cs2_low_s, temp1_s | cs1_low_s, temp2_s, temp1_s,
                              1'b0, ph2_code, ph1_code}; // [R20] [R21] [R1]

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= cmd_rd;
            if (cmd_rd) begin
                case (cmd_code)
                    `REG_TRIM_C:       rd_data_q <= trim_c_q;
                    `REG_TRIM_D:       rd_data_q <= trim_d_q;
                    `REG_BUS_OPTIONS:  rd_data_q <= options_q;
                    `REG_ADC_ACCUM:    rd_data_q <= {1'b0, acc_rdy_q, acc_q}; // [R1] [R11]
                    `REG_STORE_STATUS: rd_data_q <= store_word;
                    `REG_CODE_LOW:     rd_data_q <= {4'h0, code_low_q};
                    `REG_CODE_HIGH:    rd_data_q <= {4'h0, code_high_q};
                    `REG_FAULT_FIRST:  rd_data_q <= fault_word;
                    default:           rd_data_q <= 16'h0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// *** rail2_status_avs_config_regs_tb_top.sv ***
// Register-level testbench for the rail-2 status and options bank.
`timescale 1ns/1ps
`default_nettype none
module rail2_status_avs_config_regs_tb_top;
    bit clk, rst = 1, cmd_wr, cmd_rd, power_alert_req, avs_mode, override_mode, code_from_host, dvid_active, get_status,
        transition_done_flag, rail1_settled, rail2_settled, overcurrent_warning, undervoltage_warning, overpower_warning,
        overtemp_warning, sclk_pin, sdio_pin, avs_clk_pin, avs_mosi_pin, avs_miso_data, hot_alert_req, alert_req,
        verify_begin_command, verify_mismatch, store_command, store_write_fail, store_restore_active, store_strobe_active,
        store_live_busy, store_busy_out, store_select_in, set_code_cmd, voltage_code_valid, input_protection_source,
        clear_faults, iin_above_warn_pin, pin_above_fault_pin, rail2_temp_sense_pin, rail1_temp_sense_pin,
        rail2_cs_low_pin, rail1_cs_low_pin, rail2_modulator_self_fault, rail1_modulator_self_fault, adc_go;
    bit [7:0] cmd_code;
    bit [15:0] cmd_wdata;
    bit [3:0] phase_on_rail2, rail1_sense_fault_phase;
    bit [2:0] rail2_sense_fault_phase;
    bit [11:0] voltage_code;
    bit [49:0] rail1_sense_raw;
    bit [39:0] rail2_sense_raw;
    logic [49:0] rail1_sense_trimmed;
    logic [39:0] rail2_sense_trimmed;
    logic [15:0] rd_data_q;
    logic [9:0] adc_data;
    logic rd_valid_q, input_power_alert_out_n, status_frame_req_q, hot_alert_pin_o, hot_alert_pin_oe_n, alert_pin_o,
        alert_pin_oe_n, avs_miso_pin_q, avs_clk_q, avs_mosi_q, adc_valid, feed_busy;
    int n_fail, checks;
    rail2_status_avs_config_regs #(.BLANK_LSB_CYCLES(4)) rail2_status_avs_config_regs_i (.*);
    adc_feed adc_feed_i (.clk(clk), .go(adc_go), .adc_valid(adc_valid), .adc_data(adc_data), .feed_busy(feed_busy));
    initial forever #10 clk = ~clk;
    task chk(input logic [15:0] g, e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task wr(input bit [7:0] a, input bit [15:0] d);
        @(posedge clk);
        #1 {cmd_code, cmd_wdata, cmd_wr} = {a, d, 1'b1};
        @(posedge clk);
        #1 cmd_wr = 0;
    endtask
    task rd(input bit [7:0] a, input logic [15:0] e);
        @(posedge clk);
        #1 {cmd_code, cmd_rd} = {a, 1'b1};
        @(posedge clk);
        #1 cmd_rd = 0;
        chk(rd_valid_q, 1);
        chk(rd_data_q, e);
    endtask
    task automatic p(ref bit s);
        @(posedge clk);
        #1 s = 1;
        @(posedge clk);
        #1 s = 0;
    endtask
    initial begin
        #1000000 n_fail++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        rd(8'hA4, 16'h01FF);
        wr(8'h9B, 16'hFFFF);
        rd(8'h9B, 16'h7FFF);
        wr(8'h9D, 16'hFFFF);
        rd(8'h9D, 16'h03FF);
        wr(8'h9E, 16'hFFFF);
        rd(8'h9E, 16'hFFFF);
        wr(8'hA6, 16'hFFFF);
        rd(8'hA6, 16'h0000);
        $display("register access test done");
        p(set_code_cmd);
        for (int i = 0; i < 3; i++) begin
            #1 {voltage_code, voltage_code_valid} = {12'h300 >> i, 1'b1};
            @(posedge clk);
            #1 voltage_code_valid = 0;
        end
        rd(8'hA4, 16'h00C0);
        rd(8'hA5, 16'h0300);
        p(set_code_cmd);
        rd(8'hA5, 16'h0000);
        $display("tracker test done");
        wr(8'hA0, 16'h0000);
        p(adc_go);
        for (int i = 0; i < 99 && feed_busy; i++) @(posedge clk);
        if (feed_busy) n_fail++;
        rd(8'hA0, 16'h7FF0);
        {store_restore_active, store_busy_out, store_select_in} = 3'h7;
        p(verify_mismatch);
        p(store_write_fail);
        rd(8'hA1, 16'h0073);
        p(verify_begin_command);
        p(store_command);
        rd(8'hA1, 16'h0023);
        {rail2_modulator_self_fault, rail2_sense_fault_phase, rail1_sense_fault_phase} = 8'hEC;
        rd(8'hA6, 16'h806C);
        p(power_alert_req);
        chk(input_power_alert_out_n, 0);
        p(get_status);
        $display("status test done");
        wr(8'h9E, 16'h0002);
        override_mode = 1;
        repeat (4) begin
            #80 sclk_pin = 1;
            #80 sclk_pin = 0;
        end
        #80 sclk_pin = 1;
        repeat (5) @(posedge clk);
        chk(avs_clk_q, 1);
        chk(hot_alert_pin_oe_n, 0);
        sclk_pin = 0;
        $display("routing test done");
        end_of_test;
    end
endmodule
`default_nettype wire

// *** README_none.v ***
`timescale 1ns/1ps

// *** trim_apply.v ***
// Adds a signed five-bit trim to one digitised phase current-sense value, with saturation.
`timescale 1ns/1ps
`default_nettype none

module trim_apply #(
    parameter SENSE_W = 10
) (
    input  wire               clk,
    input  wire               rst,
    input  wire [SENSE_W-1:0] sense,
    input  wire [4:0]         trim,
    output reg  [SENSE_W-1:0] corrected_q
);

    wire signed [SENSE_W+1:0] sum_w;

    assign sum_w = $signed({2'b00, sense}) + $signed({{(SENSE_W-3){trim[4]}}, trim});

    always @(posedge clk) begin
        if (rst) begin
            corrected_q <= {SENSE_W{1'b0}};
        end else if (sum_w[SENSE_W+1]) begin
            corrected_q <= {SENSE_W{1'b0}};
        end else if (sum_w[SENSE_W]) begin
            corrected_q <= {SENSE_W{1'b1}};
        end else begin
            corrected_q <= sum_w[SENSE_W-1:0];
        end
    end

endmodule

`default_nettype wire
